// File: rtl/tape_order_consts.vh
// constants for the tape write order and detail status block
`ifndef TAPE_ORDER_CONSTS_VH
`define TAPE_ORDER_CONSTS_VH
`define ORD_NOP 16'h0000
`define ORD_WRITE 16'h2b00
`define ORD_MARK 16'h3a00
`define ORD_STATUS_HI 12'h009
`define SEL_LO 2
`define SEL_HI 0
`define FC_STATUS 6'h30
`define FC_MASK 6'h31
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define BLOCK_MAX 16'h0010
`define RETRY_STEP 3'h5
`define RETRY_ROUNDS 4'ha
`define REQ_PERIOD_NS 64
`define CLK_NS 8
`define REQ_CYCLES (`REQ_PERIOD_NS / `CLK_NS)
`define RAMP_NS 800
`define RAMP_CYCLES (`RAMP_NS / `CLK_NS)
`define WORD_LAST 3'h7
`endif

// File: rtl/word_fifo.v
// small valid/ready fifo buffering host write data
`timescale 1ns/1ps
module word_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	// occupancy
	output wire [AW:0] level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0] cnt;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt != DEPTH[AW:0]);
	assign out_valid = (cnt != {(AW+1){1'b0}});
	assign out_data = mem[rp];
	assign level = cnt;
	// pointer and count update
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wp <= wp + 1'b1;
			if (pop)
				rp <= rp + 1'b1;
			if (push && !pop)
				cnt <= cnt + 1'b1;
			else if (pop && !push)
				cnt <= cnt - 1'b1;
		end
	end
	// storage
	always @(posedge clk) begin
		if (push)
			mem[wp] <= in_data;
	end
endmodule

// File: rtl/tape_order_exec.v
// tape order executor: write, tape mark, no-op and detail status
// Overview of operation
// - tape mark order moves forward, erases, records mark, transfers no data, verifies.
// - tape mark order completes only once tape rests in following gap.
// - buffered mark queues and drops busy; second consecutive mark holds busy.
// - unbuffered write records one forward block, device makes check characters.
// - write to protected drive: no transfer, no motion, set operation check.
// - buffered write holds busy, issues timed transfer requests until adapter stop.
// - motion may start while filling; data moves to tape only at speed.
// - oversized block stops storing, keeps requesting until stop, sets data check.
// - near tape end, buffering reduced to a single block.
// - non-write command other than no-op during buffered write waits until buffer drains empty.
// - write error increments counter, retries five rewrites, up to ten rounds.
// - uncorrectable write error sets data check, reports blocks still buffered.
// - no-op moves nothing, resets status normally, refused while busy.
// - status order bits 0 to 2 pick first of eight status words.
// - status transfer continues until range spent or eight words sent.
// - detail status follows the pins every cycle, ignores changes during status order.
// - function codes 11xxx0 read status words zero to four directly.
// - response returns request data bits on address bits 0 to 15.
// - word zero holds dead track flags bits 0-7, parity bit 8.
// - word one holds read/write error flags in bits 0 to 3 and 5 to 8, bit 4 zero.
// - word three holds drive sense; word four holds check generator bits.
// - dead flags set when a track dies; diagnostic mode gives phase errors.
`timescale 1ns/1ps
`include "tape_order_consts.vh"
module tape_order_exec (
	// clock and reset
	input wire clk,
	input wire reset,
	// command from the adapter
	input wire cmd_valid,
	input wire [15:0] cmd_code,
	input wire [15:0] cmd_range,
	input wire buffered_mode,
	output reg busy,
	output reg cmd_nak,
	output reg oper_check,
	output reg data_check,
	// write data handshake
	output reg transfer_request,
	input wire wr_valid,
	input wire [15:0] wr_data,
	input wire host_stop,
	// status words out to memory
	output reg st_valid,
	output reg [15:0] st_word,
	output reg [2:0] st_index,
	// input function path
	input wire fc_valid,
	input wire [5:0] fc_code,
	input wire [15:0] fc_req_data,
	output reg fc_resp_valid,
	output reg [15:0] fc_resp_data,
	output reg [23:0] fc_resp_addr,
	// tape drive side
	output reg motion_fwd,
	output reg erase_on,
	output reg mark_write,
	output reg tape_wr_valid,
	output reg [15:0] tape_wr_data,
	input wire drive_at_speed,
	input wire mark_verified,
	input wire in_gap,
	input wire block_done,
	input wire block_error,
	// drive sense and detector pins
	input wire [8:0] track_dead,
	input wire [8:0] error_flags_in,
	input wire [8:0] sense_in,
	input wire [8:0] crc_gen_in,
	input wire diag_mode,
	input wire write_protected,
	input wire near_tape_end,
	// maintenance sense
	output reg [7:0] error_count,
	output reg [2:0] blocks_buffered
);
	localparam S_IDLE = 7'h01;
	localparam S_MARK = 7'h02;
	localparam S_FILL = 7'h04;
	localparam S_DRAIN = 7'h08;
	localparam S_RETRY = 7'h10;
	localparam S_STAT = 7'h20;
	localparam S_WAIT = 7'h40;

	reg [6:0] state;
	reg [15:0] pend_cmd;
	reg pend_valid;
	reg mark_queued;
	reg [15:0] blk_len;
	reg overflow;
	reg [7:0] req_cnt;
	reg [2:0] retry_try;
	reg [3:0] retry_round;
	reg [2:0] stat_ptr;
	reg [3:0] stat_sent;
	reg [15:0] stat_left;
	reg [15:0] dstat [0:4];
	reg [8:0] in_s1, in_s2, in_s3;
	reg [8:0] dead_s1, dead_s2, dead_s3;
	reg prot_s1, prot_s2, prot_s3;
	reg [8:0] sense_q, dead_q;
	reg prot_q;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [15:0] fifo_out_data;
	wire [2:0] fifo_level;
	wire is_status = (cmd_code[15:4] == `ORD_STATUS_HI);
	wire storing = (state == S_FILL) && wr_valid && !overflow && transfer_request;
	wire at_speed_ok = drive_at_speed;
	// one block allowed near end of tape
	wire room = near_tape_end ? (fifo_level == 3'h0) : fifo_in_ready;
	wire drain_go = fifo_out_valid && at_speed_ok && !tape_wr_valid;

	word_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_valid(storing && room),
		.in_ready(fifo_in_ready),
		.in_data(wr_data),
		.out_valid(fifo_out_valid),
		.out_ready(drain_go),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	// pin synchronisers, change counts when stages two and three agree
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			in_s1 <= 9'h000; in_s2 <= 9'h000; in_s3 <= 9'h000;
			dead_s1 <= 9'h000; dead_s2 <= 9'h000; dead_s3 <= 9'h000;
			prot_s1 <= 1'b0; prot_s2 <= 1'b0; prot_s3 <= 1'b0;
			sense_q <= 9'h000; dead_q <= 9'h000; prot_q <= 1'b0;
		end else begin
			in_s1 <= sense_in; in_s2 <= in_s1; in_s3 <= in_s2;
			dead_s1 <= track_dead; dead_s2 <= dead_s1; dead_s3 <= dead_s2;
			prot_s1 <= write_protected; prot_s2 <= prot_s1; prot_s3 <= prot_s2;
			if (in_s2 == in_s3)
				sense_q <= in_s3;
			if (dead_s2 == dead_s3)
				dead_q <= dead_s3;
			if (prot_s2 == prot_s3)
				prot_q <= prot_s3;
		end
	end

	// main order sequencer
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= S_IDLE;
			busy <= 1'b0;
			cmd_nak <= 1'b0;
			oper_check <= 1'b0;
			data_check <= 1'b0;
			transfer_request <= 1'b0;
			pend_cmd <= 16'h0000;
			pend_valid <= 1'b0;
			mark_queued <= 1'b0;
			blk_len <= 16'h0000;
			overflow <= 1'b0;
			req_cnt <= 8'h00;
			retry_try <= 3'h0;
			retry_round <= 4'h0;
			stat_ptr <= 3'h0;
			stat_sent <= 4'h0;
			stat_left <= 16'h0000;
			st_valid <= 1'b0;
			st_word <= 16'h0000;
			st_index <= 3'h0;
			motion_fwd <= 1'b0;
			erase_on <= 1'b0;
			mark_write <= 1'b0;
			tape_wr_valid <= 1'b0;
			tape_wr_data <= 16'h0000;
			error_count <= 8'h00;
			blocks_buffered <= 3'h0;
			dstat[0] <= 16'h0000; dstat[1] <= 16'h0000; dstat[2] <= 16'h0000;
			dstat[3] <= 16'h0000; dstat[4] <= 16'h0000;
		end else begin
			cmd_nak <= 1'b0;
			// no-op refused in every busy state, not only idle
			if (cmd_valid && busy && cmd_code == `ORD_NOP)
				cmd_nak <= 1'b1;
			st_valid <= 1'b0;
			blocks_buffered <= fifo_level;
			// tape side write strobe
			if (drain_go) begin
				tape_wr_valid <= 1'b1;
				tape_wr_data <= fifo_out_data;
			end else
				tape_wr_valid <= 1'b0;
			// buffered mark runs behind the adapter
			if (mark_queued && !fifo_out_valid) begin
				motion_fwd <= 1'b1;
				erase_on <= 1'b1;
				mark_write <= 1'b1;
				if (mark_verified && in_gap) begin
					mark_queued <= 1'b0;
					mark_write <= 1'b0;
					erase_on <= 1'b0;
				end
			end
			case (state)
			S_IDLE: begin
				if (cmd_valid) begin
					if (busy && cmd_code == `ORD_NOP)
						cmd_nak <= 1'b1;
					else if (cmd_code == `ORD_NOP) begin
						oper_check <= 1'b0;
						data_check <= 1'b0;
					end else if (fifo_out_valid && cmd_code != `ORD_WRITE) begin
						pend_cmd <= cmd_code;
						pend_valid <= 1'b1;
						busy <= 1'b1;
						state <= S_WAIT;
					end else if (cmd_code == `ORD_MARK) begin
						oper_check <= 1'b0;
						if (buffered_mode && !mark_queued) begin
							mark_queued <= 1'b1;
						end else begin
							busy <= 1'b1;
							state <= S_MARK;
						end
					end else if (cmd_code == `ORD_WRITE) begin
						oper_check <= 1'b0;
						if (prot_q)
							oper_check <= 1'b1;
						else begin
							busy <= 1'b1;
							motion_fwd <= 1'b1;
							blk_len <= 16'h0000;
							overflow <= 1'b0;
							req_cnt <= 8'h00;
							state <= S_FILL;
						end
					end else if (is_status) begin
						stat_ptr <= cmd_code[2:0];
						stat_sent <= 4'h0;
						stat_left <= cmd_range;
						busy <= 1'b1;
						state <= S_STAT;
					end
				end
			end
			S_MARK: begin
				if (!mark_queued) begin
					motion_fwd <= 1'b1;
					erase_on <= 1'b1;
					mark_write <= 1'b1;
					if (mark_verified && in_gap) begin
						mark_write <= 1'b0;
						erase_on <= 1'b0;
						motion_fwd <= 1'b0;
						busy <= 1'b0;
						state <= S_IDLE;
					end
				end
			end
			S_FILL: begin
				if (req_cnt == `REQ_CYCLES - 1) begin
					req_cnt <= 8'h00;
					transfer_request <= !host_stop;
				end else begin
					req_cnt <= req_cnt + 8'h01;
					if (wr_valid)
						transfer_request <= 1'b0;
				end
				if (storing) begin
					blk_len <= blk_len + 16'h0001;
					if (blk_len == `BLOCK_MAX || !room)
						overflow <= 1'b1;
				end
				if (host_stop) begin
					transfer_request <= 1'b0;
					if (overflow)
						data_check <= 1'b1;
					busy <= 1'b0;
					state <= buffered_mode ? S_IDLE : S_DRAIN;
				end
			end
			S_DRAIN: begin
				if (block_error) begin
					error_count <= error_count + 8'h01;
					retry_try <= 3'h0;
					retry_round <= 4'h0;
					state <= S_RETRY;
				end else if (block_done && !fifo_out_valid) begin
					motion_fwd <= 1'b0;
					state <= S_IDLE;
				end
			end
			S_RETRY: begin
				erase_on <= 1'b1;
				if (block_done) begin
					erase_on <= 1'b0;
					state <= S_DRAIN;
				end else if (block_error) begin
					error_count <= error_count + 8'h01;
					if (retry_try == `RETRY_STEP - 3'h1) begin
						retry_try <= 3'h0;
						if (retry_round == `RETRY_ROUNDS - 4'h1) begin
							data_check <= 1'b1;
							erase_on <= 1'b0;
							state <= S_IDLE;
						end else
							retry_round <= retry_round + 4'h1;
					end else
						retry_try <= retry_try + 3'h1;
				end
			end
			S_STAT: begin
				// frozen copy, not refreshed while status runs
				st_valid <= 1'b1;
				st_word <= (stat_ptr > 3'h4) ? 16'h0000 : dstat[stat_ptr];
				st_index <= stat_ptr;
				stat_ptr <= stat_ptr + 3'h1;
				stat_sent <= stat_sent + 4'h1;
				stat_left <= stat_left - 16'h0001;
				if (stat_left <= 16'h0001 || stat_sent == {1'b0, `WORD_LAST}) begin
					busy <= 1'b0;
					state <= S_IDLE;
				end
			end
			S_WAIT: begin
				if (!fifo_out_valid && !mark_queued) begin
					pend_valid <= 1'b0;
					busy <= 1'b0;
					state <= S_IDLE;
				end
			end
			default: state <= S_IDLE;
			endcase
			// capture detail status every cycle, except while a status order starts or runs
			if (state != S_STAT && !(state == S_IDLE && cmd_valid && is_status)) begin
				dstat[0] <= {7'h00, dead_q | (diag_mode ? error_flags_in : 9'h000)};
				dstat[1] <= {7'h00, error_flags_in[8:5], 1'b0, error_flags_in[3:0]};
				dstat[2] <= 16'h0000;
				dstat[3] <= {7'h00, sense_q};
				dstat[4] <= {7'h00, crc_gen_in};
			end
		end
	end

	// direct function code reads
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			fc_resp_valid <= 1'b0;
			fc_resp_data <= 16'h0000;
			fc_resp_addr <= 24'h000000;
		end else begin
			fc_resp_valid <= fc_valid && fc_code[5:4] == 2'b11 && !fc_code[0];
			fc_resp_data <= (fc_code[3:1] > 3'h4) ? 16'h0000 : dstat[fc_code[3:1]];
			fc_resp_addr <= {8'h00, fc_req_data};
		end
	end
endmodule

// File: sim/tape_order_monitor.sv
// assertion checker bound to the tape order executor
`timescale 1ns/1ps
module tape_order_monitor (
	// clock and reset
	input wire clk,
	input wire reset,
	// command side
	input wire cmd_valid,
	input wire [15:0] cmd_code,
	input wire buffered_mode,
	input wire write_protected,
	input wire busy,
	input wire cmd_nak,
	input wire oper_check,
	// write data and tape
	input wire transfer_request,
	input wire host_stop,
	input wire mark_write,
	input wire tape_wr_valid,
	// status paths
	input wire st_valid,
	input wire [2:0] st_index,
	input wire fc_valid,
	input wire [5:0] fc_code,
	input wire [15:0] fc_req_data,
	input wire fc_resp_valid,
	input wire [23:0] fc_resp_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// command taken while idle
	wire take = cmd_valid && !busy;
	a_nop_refused: assert property (busy && cmd_valid && ~|cmd_code |=> cmd_nak)
		else $error("no-op while busy not refused");
	a_protect_refused: assert property (take && cmd_code == 16'h2b00 && write_protected
		&& $past(write_protected, 6) |=> oper_check && !busy) else $error("protected write ran");
	a_request_busy: assert property (transfer_request |-> busy)
		else $error("request while not busy");
	a_stop_release: assert property (busy && host_stop |=> !busy)
		else $error("busy held after stop");
	a_mark_holds: assert property (take && cmd_code == 16'h3a00 && !buffered_mode |=> busy[*8])
		else $error("unbuffered mark dropped busy early");
	a_mark_no_data: assert property (mark_write |-> !tape_wr_valid)
		else $error("data moved during mark");
	a_fc_echo: assert property (fc_valid && fc_code[5:4] == 2'b11 && !fc_code[0]
		|=> fc_resp_valid && fc_resp_addr[15:0] == $past(fc_req_data)) else $error("bad echo");
	a_index_wraps: assert property (st_valid && $past(st_valid)
		|-> st_index == $past(st_index) + 3'h1) else $error("status index skipped");
	c_nak: cover property (cmd_nak);
	c_buf_write: cover property (take && buffered_mode && cmd_code == 16'h2b00);
	c_wrap: cover property (st_valid && st_index == 3'h7 ##1 st_valid);
endmodule
bind tape_order_exec tape_order_monitor mon (.clk, .reset, .cmd_valid, .cmd_code, .buffered_mode,
	.write_protected, .busy, .cmd_nak, .oper_check, .transfer_request, .host_stop, .mark_write,
	.tape_wr_valid, .st_valid, .st_index, .fc_valid, .fc_code, .fc_req_data, .fc_resp_valid,
	.fc_resp_addr);

// File: sim/host_adapter_model.sv
// host adapter model answering transfer requests with write words
`timescale 1ns/1ps
module host_adapter_model (
	// clock and reset
	input wire clk,
	input wire reset,
	// bench control
	input wire go,
	input wire slow,
	input wire [7:0] nwords,
	// write data handshake
	input wire transfer_request,
	output reg wr_valid,
	output reg [15:0] wr_data,
	output reg host_stop
);
	reg [7:0] sent;
	reg [1:0] lag;
	reg pend;
	// one word per request, late when slow, then a single stop pulse
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_valid <= 1'b0;
			wr_data <= 16'h0000;
			host_stop <= 1'b0;
			sent <= 8'h00;
			lag <= 2'h0;
			pend <= 1'b0;
		end else begin
			wr_valid <= 1'b0;
			host_stop <= 1'b0;
			wr_data <= ~wr_data; // idle data inverts every cycle
			if (!go) begin
				sent <= 8'h00;
			end else if (pend && lag != 2'h0) begin
				lag <= lag - 2'h1;
			end else if (pend) begin
				pend <= 1'b0;
				wr_valid <= 1'b1;
				wr_data <= 16'ha500 + {8'h00, sent};
				sent <= sent + 8'h01;
			end else if (transfer_request && !wr_valid && sent < nwords) begin
				pend <= 1'b1;
				lag <= slow ? 2'h3 : 2'h0;
			end else if (sent == nwords) begin
				host_stop <= 1'b1;
				sent <= sent + 8'h01;
			end
		end
	end
endmodule

// File: sim/tape_order_exec_bench.sv
// self-checking bench for the tape order executor
`timescale 1ns/1ps
module tape_order_exec_bench;
	reg clk, reset, cmd_valid, buffered_mode, fc_valid, go, slow, nak_seen;
	reg drive_at_speed, mark_verified, in_gap, block_done, write_protected;
	reg [15:0] cmd_code, cmd_range, fc_req_data;
	reg [8:0] track_dead, error_flags_in, sense_in, crc_gen_in;
	reg [7:0] nwords;
	reg [5:0] fc_code;
	wire busy, cmd_nak, oper_check, transfer_request, wr_valid, host_stop, st_valid;
	wire fc_resp_valid, tape_wr_valid;
	wire [15:0] wr_data, tape_wr_data, fc_resp_data;
	wire [23:0] fc_resp_addr;
	wire [2:0] st_index;
	integer mismatches = 0, comparisons = 0, cycles = 0, i, j;
	logic [15:0] fcq[$], stq[$], twq[$], fdq[$];
	tape_order_exec dut (.clk, .reset, .cmd_valid, .cmd_code, .cmd_range, .buffered_mode, .busy,
		.cmd_nak, .oper_check, .data_check(), .transfer_request, .wr_valid, .wr_data, .host_stop,
		.st_valid, .st_word(), .st_index, .fc_valid, .fc_code, .fc_req_data, .fc_resp_valid,
		.fc_resp_data, .fc_resp_addr, .motion_fwd(), .erase_on(), .mark_write(), .tape_wr_valid,
		.tape_wr_data, .drive_at_speed, .mark_verified, .in_gap, .block_done, .block_error(1'b0),
		.track_dead, .error_flags_in, .sense_in, .crc_gen_in, .diag_mode(1'b0),
		.write_protected, .near_tape_end(1'b0), .error_count(), .blocks_buffered());
	host_adapter_model far (.clk, .reset, .go, .slow, .nwords, .transfer_request, .wr_valid,
		.wr_data, .host_stop);
	// compare one result against its note
	task check(input [23:0] got, input [23:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one command pulse, launched off the sampling edge
	task cmd(input [15:0] code, input [15:0] range);
		@(negedge clk);
		cmd_code = code;
		cmd_range = range;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		@(negedge clk);
	endtask
	task wait_idle;
		j = 0;
		while (busy !== 1'b0 && j < 400) begin
			@(negedge clk);
			j = j + 1;
		end
		check({23'h0, busy}, 24'h0);
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// cycle ceiling against hangs
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			mismatches = mismatches + 1;
			tally_and_finish;
		end
	end
	// pair each result with the oldest note of its kind
	always @(negedge clk) begin
		if (cmd_nak === 1'b1)
			nak_seen = 1'b1;
		if (fc_resp_valid === 1'b1 && fcq.size() > 0)
			check({8'h00, fc_resp_addr[15:0]}, {8'h00, fcq.pop_front()});
		if (fc_resp_valid === 1'b1 && fdq.size() > 0)
			check({8'h00, fc_resp_data}, {8'h00, fdq.pop_front()});
		if (st_valid === 1'b1 && stq.size() > 0)
			check({21'h0, st_index}, {8'h00, stq.pop_front()});
		if (tape_wr_valid === 1'b1 && twq.size() > 0)
			check({8'h00, tape_wr_data}, {8'h00, twq.pop_front()});
	end
	initial begin
		void'($urandom(32'h474b));
		{reset, cmd_valid, buffered_mode, fc_valid, go, slow, nak_seen} = 7'h40;
		{drive_at_speed, mark_verified, in_gap, block_done, write_protected} = 5'h10;
		{cmd_code, cmd_range, fc_req_data, fc_code, nwords} = 62'h0;
		track_dead = 9'($urandom);
		error_flags_in = 9'($urandom);
		sense_in = 9'($urandom);
		crc_gen_in = 9'($urandom);
		repeat (5) @(negedge clk);
		reset = 1'b0;
		// unbuffered mark holds busy; a no-op meanwhile is refused
		cmd(16'h3a00, 16'h0001);
		check({23'h0, busy}, 24'h1);
		nak_seen = 1'b0;
		cmd(16'h0000, 16'h0001);
		check({23'h0, nak_seen}, 24'h1);
		repeat (6) @(negedge clk);
		check({23'h0, busy}, 24'h1);
		mark_verified = 1'b1;
		in_gap = 1'b1;
		wait_idle;
		{mark_verified, in_gap} = 2'b00;
		// protected write is refused, a no-op then clears the status
		write_protected = 1'b1;
		repeat (8) @(negedge clk);
		cmd(16'h2b00, 16'h0001);
		@(negedge clk);
		check({22'h0, oper_check, busy}, 24'h2);
		write_protected = 1'b0;
		repeat (8) @(negedge clk);
		cmd(16'h0000, 16'h0001);
		@(negedge clk);
		check({23'h0, oper_check}, 24'h0);
		// buffered writes, prompt then slow adapter, tape up to speed late
		buffered_mode = 1'b1;
		for (i = 0; i < 2; i = i + 1) begin
			nwords = 8'($urandom % 4 + 1);
			slow = i[0];
			drive_at_speed = 1'b0;
			for (j = 0; j < nwords; j = j + 1)
				twq.push_back(16'ha500 + 16'(j));
			go = 1'b1;
			cmd(16'h2b00, {8'h00, nwords});
			repeat (20) @(negedge clk);
			drive_at_speed = 1'b1;
			wait_idle;
			go = 1'b0;
			repeat (150) @(negedge clk);
			block_done = 1'b1;
			@(negedge clk);
			block_done = 1'b0;
		end
		// buffered mark is stacked and releases busy
		cmd(16'h3a00, 16'h0001);
		repeat (2) @(negedge clk);
		check({23'h0, busy}, 24'h0);
		{mark_verified, in_gap} = 2'b11;
		repeat (4) @(negedge clk);
		{mark_verified, in_gap, buffered_mode} = 3'b000;
		// status order from several first words and ranges, with wrap
		for (i = 0; i < 4; i = i + 1) begin
			for (j = 0; j < (i * 4 + 1 > 8 ? 8 : i * 4 + 1); j = j + 1)
				stq.push_back(16'((7 - i * 2 + j) % 8));
			cmd(16'h0090 + 16'(7 - i * 2), 16'(i * 4 + 1));
			wait_idle;
		end
		// status function codes for words zero to four echo their request data
		for (i = 0; i < 5; i = i + 1) begin
			fc_code = {2'b11, i[2:0], 1'b0};
			fc_req_data = 16'($urandom);
			fcq.push_back(fc_req_data);
			fdq.push_back(i == 0 ? {7'h0, track_dead} : i == 1 ? {7'h0, error_flags_in[8:5],
				1'b0, error_flags_in[3:0]} : i == 3 ? {7'h0, sense_in} : i == 4 ?
				{7'h0, crc_gen_in} : 16'h0);
			fc_valid = 1'b1;
			@(negedge clk);
			fc_valid = 1'b0;
			@(negedge clk);
		end
		repeat (10) @(negedge clk);
		check(24'(fcq.size() + stq.size() + twq.size() + fdq.size()), 24'h0);
		tally_and_finish;
	end
endmodule
